// >>> testbench/ifcld_core_properties.sv
`timescale 1ns/100ps
`include "ifcld_map.svh"

// Port-level checks of the IF counter block: bus handshakes, interrupt and pin.
module ifcld_core_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic data_out_o,
	input wire logic data_out_oe_n,
	input wire logic irq
);
	// One clock domain, so one clocking and one reset guard serve all checks.
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Responses wait unchanged until the master takes them.
	chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
	chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data not held");
	// Answers come a fixed number of cycles after the request is taken.
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer mistimed");
	// A pending answer blocks the next request on that side.
	chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while answer pending");
	chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while answer pending");
	chk_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read returned data");
	// Leaving reset, everything is quiet and the pin released.
	chk_reset_idle: assert property ($rose(aresetn) |-> data_out_oe_n && !irq && !s_axi_bvalid
		&& !s_axi_rvalid) else $error("outputs busy after reset");
	// Clearing the whole mask must silence the interrupt.
	chk_mask_quiet: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && s_axi_awaddr == `IFCLD_REG_IRQ_MASK && s_axi_wstrb[0]
		&& s_axi_wdata[1:0] == 2'h0 |-> ##[2:3] !irq) else $error("masked interrupt still high");
	// The open-drain pin can only ever pull low.
	chk_pin_pull: assert property (data_out_o == 1'b0)
		else $error("pin driven high");
endmodule : ifcld_core_properties

bind ifcld_core ifcld_core_properties u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .data_out_o, .data_out_oe_n, .irq);

// >>> testbench/ifcld_host_model.sv
`timescale 1ns/100ps

// Host controller on the four-wire link; its shift clock runs only in frames.
module ifcld_host_model (
	output logic chip_enable_pin,
	output logic shift_clock_pin,
	output logic data_in_pin,
	input wire logic dout
);
	localparam real HALF = 62.5; // Half of the 125 ns shift period.
	logic [20:0] rd_val; // Lock flag above the twenty count bits.
	event rd_done; // Fires once a read frame has been collected.

	// Pins idle low from time zero.
	initial
	begin
		chip_enable_pin = 1'b0;
		shift_clock_pin = 1'b0;
		data_in_pin = 1'b0;
	end

	// Write frame: a zero picks the direction, then n bits, lowest first.
	task automatic send(input logic [27:0] w, input int n);
		chip_enable_pin = 1'b1;
		for (int i = -1; i < n; i++)
		begin
			data_in_pin = (i < 0) ? 1'b0 : w[i];
			#HALF;
			shift_clock_pin = 1'b1;
			#HALF;
			shift_clock_pin = 1'b0;
		end
		#HALF;
		chip_enable_pin = 1'b0;
		data_in_pin = ~data_in_pin; // Released data line must not keep its last value.
	endtask : send

	// Read frame: the flag shows at the direction edge, each falling edge moves on.
	task automatic fetch();
		chip_enable_pin = 1'b1;
		data_in_pin = 1'b1;
		#HALF;
		shift_clock_pin = 1'b1;
		#HALF;
		rd_val[20] = dout;
		for (int i = 19; i >= 0; i--)
		begin
			shift_clock_pin = 1'b0;
			#HALF;
			rd_val[i] = dout;
			shift_clock_pin = 1'b1;
			#HALF;
		end
		shift_clock_pin = 1'b0;
		#HALF;
		chip_enable_pin = 1'b0;
		data_in_pin = ~data_in_pin;
		-> rd_done;
	endtask : fetch
endmodule : ifcld_host_model

// >>> testbench/tb.sv
`timescale 1ns/100ps
`include "ifcld_map.svh"

// Self-checking bench: AXI master, pulse sources and a host on the link.
module tb;
	localparam int GC[4] = '{40, 80, 320, 640}; // Shortened gate lengths in cycles.
	localparam int RC9 = 50, RC25 = 60, RC5 = 70, RC1 = 100; // Reference periods.
	// Reference code, path, speed and divisor of each lock case.
	localparam logic [27:0] LT[8] = '{28'h901000A, 28'h9010005, 28'h90000A7, 28'h9100005,
		28'h201000C, 28'hA01000E, 28'h0010014, 28'h001000A};
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1; // Always ready for answers.
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic chip_enable_pin, shift_clock_pin, data_in_pin, data_out_o, data_out_oe_n;
	logic if_input_pin = 1'b0, am_input_pin = 1'b0, fm_input_pin = 1'b0;
	logic [2:0] ic = 3'h0, pc = 3'h0;
	logic [33:0] exp_q[$]; // Expected results, oldest first.
	logic [27:0] w;
	logic lk;
	int dv, num_errors = 0, n_checks = 0, seed = 46;
	event probe_ev;
	wire dout_pin = data_out_oe_n ? 1'b1 : data_out_o; // Pull-up holds a released pin high.

	ifcld_core #(.GATE0_CYC(GC[0]), .GATE1_CYC(GC[1]), .GATE2_CYC(GC[2]), .GATE3_CYC(GC[3]),
		.WAIT_SHORT_CYC(30), .WAIT_LONG_CYC(60), .REF_9K_CYC(RC9), .REF_25K_CYC(RC25),
		.REF_5K_CYC(RC5), .REF_1K_CYC(RC1)) u_ifcld_core (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_enable_pin,
		.shift_clock_pin, .data_in_pin, .data_out_o, .data_out_oe_n, .if_input_pin,
		.am_input_pin, .fm_input_pin, .irq);
	ifcld_host_model u_host (.chip_enable_pin, .shift_clock_pin, .data_in_pin, .dout(dout_pin));

	always #4 aclk = ~aclk;

	// IF runs at an eighth of the clock whenever counting; oscillators at a fifth.
	always @(posedge aclk)
	begin
		ic <= ic + 3'h1;
		if_input_pin <= ic[2];
		pc <= (pc == 3'h4) ? 3'h0 : pc + 3'h1;
		am_input_pin <= (pc < 3'h2);
		fm_input_pin <= (pc < 3'h2);
	end

	// Compares one result with its expectation and counts both.
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Results are taken off the queue in the order they appear.
	always @(posedge aclk)
	begin
		if (s_axi_rvalid && s_axi_rready)
			check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			check({s_axi_bresp, 32'h0}, exp_q.pop_front());
	end
	always @(u_host.rd_done) check({13'h0, u_host.rd_val}, exp_q.pop_front());
	always @(probe_ev) check({32'h0, irq, dout_pin}, exp_q.pop_front());

	// Serial word with reduced sensitivity, since no detect input exists.
	function automatic logic [27:0] mk(input logic [15:0] n, input logic sp, input logic pa,
		input logic arm, input logic [3:0] rc, input logic [1:0] g);
		return {2'b00, g, rc, 1'b0, arm, pa, sp, n};
	endfunction : mk

	function automatic int refc(input logic [3:0] c);
		return (c == 4'h9) ? RC9 : (c == 4'h2) ? RC25 : (c == 4'hA) ? RC5 : RC1;
	endfunction : refc

	// Bus write; address and data go out together and drop as each is taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		exp_q.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
			begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
	endtask : wr

	// Bus read; the answer is compared by the monitor.
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
	endtask : rd

	// Frame out, then a few cycles for the pins to cross into the clock domain.
	task automatic put(input logic [27:0] v, input int n);
		u_host.send(v, n);
		repeat (6) @(posedge aclk);
	endtask : put

	task automatic serial_rd(input logic [20:0] e);
		exp_q.push_back({13'h0, e});
		u_host.fetch();
		repeat (8) @(posedge aclk);
	endtask : serial_rd

	// One edge first, so the bus monitor has taken its own result off the queue.
	task automatic probe(input logic [1:0] e);
		@(posedge aclk);
		exp_q.push_back({32'h0, e});
		-> probe_ev;
	endtask : probe

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	// Main sequence: registers, one count per gate code, then the lock cases.
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		rd(`IFCLD_REG_CTRL, 34'h2);
		rd(8'h14, {2'h2, 32'h0});
		wr(8'h14, 32'h1, 2'h2);
		wr(`IFCLD_REG_CTRL, 32'h0, 2'h0); // Detection off, so the flag reads one.
		wr(`IFCLD_REG_IRQ_MASK, 32'h1, 2'h0);
		for (int g = 0; g < 4; g++)
		begin
			w = mk(16'($random(seed)), 1'($random(seed)), 1'($random(seed)), 1'b0, 4'h0, g[1:0]);
			put(w, 28);
			serial_rd({1'b1, 20'h0});
			w[18] = 1'b1;
			put(w, 28);
			rd(`IFCLD_REG_WORD, {6'h0, w});
			rd(`IFCLD_REG_STATUS, 34'h300000);
			while (irq !== 1'b1) @(posedge aclk);
			rd(`IFCLD_REG_STATUS, 34'h500000 + 34'(GC[g] / 8));
			serial_rd({1'b1, 20'(GC[g] / 8)});
			put(w ^ 28'h1, 27); // A short frame is dropped.
			rd(`IFCLD_REG_WORD, {6'h0, w});
			wr(`IFCLD_REG_IRQ_MASK, 32'h0, 2'h0);
			probe(2'b01);
			wr(`IFCLD_REG_IRQ_MASK, 32'h1, 2'h0);
			probe(2'b11);
			wr(`IFCLD_REG_IRQ_STAT, 32'h1, 2'h0);
			probe(2'b01);
		end
		wr(`IFCLD_REG_CTRL, 32'h3, 2'h0); // Detection on, pin shows lock state.
		foreach (LT[i])
		begin
			dv = LT[i][20] ? 2 * LT[i][15:0] : LT[i][16] ? LT[i][15:0] : LT[i][15:4];
			lk = (dv * 5 == refc(LT[i][27:24]));
			put(mk(LT[i][15:0], LT[i][16], LT[i][20], 1'b1, LT[i][27:24], 2'h3), 28);
			repeat (800) @(posedge aclk);
			repeat (2)
			begin
				serial_rd({lk, 20'd80});
				probe({1'b0, lk});
			end
		end
		conclude();
	end

	// Watchdog well beyond the expected run length.
	initial
	begin
		#600000;
		num_errors++;
		conclude();
	end
endmodule : tb

// >>> verilog/ifcld_core.sv
`timescale 1ns/100ps
`include "ifcld_map.svh"

module ifcld_core
	import ifcld_pkg::*;
#(
	parameter int unsigned GATE0_CYC = `IFCLD_GATE0_MS * `IFCLD_CLK_KHZ,
	parameter int unsigned GATE1_CYC = `IFCLD_GATE1_MS * `IFCLD_CLK_KHZ,
	parameter int unsigned GATE2_CYC = `IFCLD_GATE2_MS * `IFCLD_CLK_KHZ,
	parameter int unsigned GATE3_CYC = `IFCLD_GATE3_MS * `IFCLD_CLK_KHZ,
	parameter int unsigned WAIT_SHORT_CYC = `IFCLD_WAIT_SHORT_MS * `IFCLD_CLK_KHZ,
	parameter int unsigned WAIT_LONG_CYC = `IFCLD_WAIT_LONG_MS * `IFCLD_CLK_KHZ,
	parameter int unsigned REF_9K_CYC = `IFCLD_CLK_HZ / `IFCLD_REF_9K_HZ,
	parameter int unsigned REF_25K_CYC = `IFCLD_CLK_HZ / `IFCLD_REF_25K_HZ,
	parameter int unsigned REF_5K_CYC = `IFCLD_CLK_HZ / `IFCLD_REF_5K_HZ,
	parameter int unsigned REF_1K_CYC = `IFCLD_CLK_HZ / `IFCLD_REF_1K_HZ
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic chip_enable_pin,
	input wire logic shift_clock_pin,
	input wire logic data_in_pin,
	output logic data_out_o,
	output logic data_out_oe_n,
	input wire logic if_input_pin,
	input wire logic am_input_pin,
	input wire logic fm_input_pin,
	output logic irq
);
	import ifcld_pkg::*;

	ifcld_state_type st; // Registered state.
	ifcld_state_type next_st; // Value for the next edge.
	logic [5:0] pins_sync; // Pins after two flip-flops.
	logic ce_s, cl_s, di_s, if_s, am_s, fm_s; // Named synchronised pins.

	// All pins come from outside the clock domain and pass two stages first.
	ifcld_sync #(.W(6)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({chip_enable_pin, shift_clock_pin, data_in_pin,
			if_input_pin, am_input_pin, fm_input_pin}),
		.q(pins_sync)
	);
	assign {ce_s, cl_s, di_s, if_s, am_s, fm_s} = pins_sync;

	// Cycles of one reference period for a select code; unknown codes fall back to 1 kHz.
	function automatic logic [23:0] ref_cycles(input logic [3:0] code);
		unique case (code)
			`IFCLD_REF_9K_CODE: ref_cycles = 24'(REF_9K_CYC);
			`IFCLD_REF_25K_CODE: ref_cycles = 24'(REF_25K_CYC);
			`IFCLD_REF_5K_CODE: ref_cycles = 24'(REF_5K_CYC);
			default: ref_cycles = 24'(REF_1K_CYC);
		endcase
	endfunction : ref_cycles

	// Gate length for the two gate-select bits.
	function automatic logic [23:0] gate_cycles(input logic [1:0] sel);
		unique case (sel)
			2'h0: gate_cycles = 24'(GATE0_CYC);
			2'h1: gate_cycles = 24'(GATE1_CYC);
			2'h2: gate_cycles = 24'(GATE2_CYC);
			2'h3: gate_cycles = 24'(GATE3_CYC);
		endcase
	endfunction : gate_cycles

	logic [15:0] divisor; // Divisor field of the applied word.
	logic [3:0] ref_sel; // Reference select field.
	logic [1:0] gate_sel; // Gate select, high bit first.
	logic [16:0] div_n; // Effective division ratio.
	logic lock_flag; // Reported lock state.
	logic ce_fall, cl_rise, cl_fall, if_rise, vco_rise, ref_tick; // Event strobes.
	logic wr_fire, wr_ok, rd_ok; // Bus write and decode results.
	logic [1:0] ev; // Interrupt events of this cycle.

	assign divisor = st.word[`IFCLD_W_DIV_LSB +: 16];
	assign ref_sel = st.word[`IFCLD_W_REF_LSB +: 4];
	assign gate_sel = {st.word[`IFCLD_W_GATE_HI], st.word[`IFCLD_W_GATE_LO]};
	assign lock_flag = st.locked | ~st.ctrl_lock_en;

	// Division ratio per path; a zero ratio is kept at one so the divider never stalls.
	always_comb
	begin
		if (st.word[`IFCLD_W_PRESC_PATH])
			div_n = {divisor, 1'b0};
		else if (st.word[`IFCLD_W_AM_SPEED])
			div_n = {1'b0, divisor};
		else
			div_n = {5'h00, divisor[15:4]};
		if (div_n == 17'h00000)
			div_n = 17'h00001;
	end

	// Edge strobes are taken from the synchronised levels only.
	assign ce_fall = st.prev_ce & ~ce_s;
	assign cl_rise = ~st.prev_cl & cl_s;
	assign cl_fall = st.prev_cl & ~cl_s;
	assign if_rise = ~st.prev_if & if_s;
	assign vco_rise = ~st.prev_vco & (st.word[`IFCLD_W_PRESC_PATH] ? fm_s : am_s);
	assign ref_tick = (st.ref_cnt == 24'h000000);

	// Bus handshakes are combinational; a response blocks new requests of its kind.
	assign s_axi_awready = ~st.aw_got & ~st.bvalid;
	assign s_axi_wready = ~st.w_got & ~st.bvalid;
	assign s_axi_arready = ~st.rvalid;
	assign wr_fire = st.aw_got & st.w_got & ~st.bvalid;
	assign wr_ok = (st.aw_addr == `IFCLD_REG_CTRL) | (st.aw_addr == `IFCLD_REG_IRQ_STAT)
		| (st.aw_addr == `IFCLD_REG_IRQ_MASK) | (st.aw_addr == `IFCLD_REG_STATUS)
		| (st.aw_addr == `IFCLD_REG_WORD);
	assign rd_ok = (s_axi_araddr == `IFCLD_REG_CTRL) | (s_axi_araddr == `IFCLD_REG_STATUS)
		| (s_axi_araddr == `IFCLD_REG_WORD) | (s_axi_araddr == `IFCLD_REG_IRQ_STAT)
		| (s_axi_araddr == `IFCLD_REG_IRQ_MASK);

	// Next-state logic for the bus slave, the serial link, the counter and the lock detector.
	always_comb
	begin
		next_st = st;
		ev = 2'h0;
		next_st.prev_ce = ce_s;
		next_st.prev_cl = cl_s;
		next_st.prev_if = if_s;
		next_st.prev_vco = vco_rise ? 1'b1 : (st.word[`IFCLD_W_PRESC_PATH] ? fm_s : am_s);

		// Write address and data are caught in either order.
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_st.aw_got = 1'b1;
			next_st.aw_addr = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_st.w_got = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_lane0 = s_axi_wstrb[0];
		end

		// Read answers one cycle after the address; an unknown address gets SLVERR, and zero unless it lies inside a mapped word.
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_st.rvalid = 1'b1;
			next_st.rresp = rd_ok ? 2'h0 : 2'h2;
			unique case ({s_axi_araddr[7:2], 2'b00})
				`IFCLD_REG_CTRL: next_st.rdata = {30'h00000000, st.ctrl_lock_en, st.ctrl_lock_pin};
				`IFCLD_REG_STATUS: next_st.rdata = {9'h000, st.cnt_state == CNT_DONE,
					st.cnt_state == CNT_WAIT || st.cnt_state == CNT_GATE, lock_flag, st.if_count};
				`IFCLD_REG_WORD: next_st.rdata = {4'h0, st.word};
				`IFCLD_REG_IRQ_STAT: next_st.rdata = {30'h00000000, st.irq_stat};
				`IFCLD_REG_IRQ_MASK: next_st.rdata = {30'h00000000, st.irq_mask};
				default: next_st.rdata = 32'h00000000;
			endcase
		end
		else if (st.rvalid && s_axi_rready)
			next_st.rvalid = 1'b0;

		// Serial link: a frame opens when chip enable rises.
		if (ce_s && !st.prev_ce)
		begin
			next_st.in_frame = 1'b1;
			next_st.dir_known = 1'b0;
			next_st.in_read = 1'b0;
			next_st.bit_cnt = 5'h00;
		end
		else if (st.in_frame && ce_s && cl_rise && !st.dir_known)
		begin
			// The first bit picks the direction; a read captures flag and count at once.
			next_st.dir_known = 1'b1;
			next_st.in_read = di_s;
			next_st.out_sr = {lock_flag, st.if_count};
		end
		else if (st.in_frame && ce_s && cl_rise && !st.in_read
			&& st.bit_cnt != 5'(`IFCLD_WORD_LEN))
		begin
			// Bits arrive first-field-first and settle at index 0 upward.
			next_st.shift_in = {di_s, st.shift_in[27:1]};
			next_st.bit_cnt = st.bit_cnt + 5'h01;
		end
		else if (st.in_frame && ce_s && cl_fall && st.in_read)
			next_st.out_sr = {st.out_sr[19:0], 1'b1};

		// The word takes effect only on chip enable falling after a whole word.
		if (ce_fall)
		begin
			next_st.in_frame = 1'b0;
			next_st.in_read = 1'b0;
			if (st.dir_known && !st.in_read && st.bit_cnt == 5'(`IFCLD_WORD_LEN))
			begin
				next_st.word = st.shift_in;
				if (!st.shift_in[`IFCLD_W_ARM])
				begin
					next_st.cnt_state = CNT_IDLE;
					next_st.if_count = 20'h00000;
				end
				else if (!st.word[`IFCLD_W_ARM])
				begin
					// Wait is timed from this very edge so the IF signal can settle.
					next_st.cnt_state = CNT_WAIT;
					next_st.if_count = 20'h00000;
					next_st.cyc_cnt = st.shift_in[`IFCLD_W_GATE_HI] ? 24'(WAIT_LONG_CYC)
						: 24'(WAIT_SHORT_CYC);
				end
			end
		end
		else
		begin
			// Count phases run only in cycles where chip enable does not fall.
			unique case (st.cnt_state)
				CNT_IDLE: next_st.cyc_cnt = 24'h000000;
				CNT_WAIT:
					if (st.cyc_cnt <= 24'h000001)
					begin
						next_st.cnt_state = CNT_GATE;
						next_st.cyc_cnt = gate_cycles(gate_sel);
					end
					else
						next_st.cyc_cnt = st.cyc_cnt - 24'h000001;
				CNT_GATE:
				begin
					if (if_rise)
						next_st.if_count = st.if_count + 20'h00001;
					if (st.cyc_cnt <= 24'h000001)
					begin
						next_st.cnt_state = CNT_DONE;
						ev[`IFCLD_IRQ_DONE] = 1'b1;
					end
					else
						next_st.cyc_cnt = st.cyc_cnt - 24'h000001;
				end
				CNT_DONE: next_st.cyc_cnt = 24'h000000;
			endcase
		end

		// Divided oscillator pulses are tallied per reference period.
		if (vco_rise)
		begin
			if (st.div_cnt >= div_n - 17'h00001)
			begin
				next_st.div_cnt = 17'h00000;
				if (st.fp_cnt != 2'h3)
					next_st.fp_cnt = st.fp_cnt + 2'h1;
			end
			else
				next_st.div_cnt = st.div_cnt + 17'h00001;
		end

		// Lock is judged once per period: exactly one divided pulse means locked.
		if (ref_tick)
		begin
			next_st.ref_cnt = ref_cycles(ref_sel) - 24'h000001;
			next_st.locked = (st.fp_cnt == 2'h1);
			// A divided pulse that lands on the tick itself opens the new period, else a
			// divider in step with the reference would never be seen as locked.
			next_st.fp_cnt = (next_st.fp_cnt != st.fp_cnt) ? 2'h1 : 2'h0;
			if (st.locked != (st.fp_cnt == 2'h1))
				ev[`IFCLD_IRQ_LOCK] = 1'b1;
		end
		else
			next_st.ref_cnt = st.ref_cnt - 24'h000001;

		// Register writes; status bits clear on a one, but a new event wins.
		if (wr_fire)
		begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = wr_ok ? 2'h0 : 2'h2;
			if (st.w_lane0)
			begin
				if (st.aw_addr == `IFCLD_REG_CTRL)
				begin
					next_st.ctrl_lock_pin = st.w_data[`IFCLD_CTRL_LOCK_PIN];
					next_st.ctrl_lock_en = st.w_data[`IFCLD_CTRL_LOCK_EN];
				end
				if (st.aw_addr == `IFCLD_REG_IRQ_MASK)
					next_st.irq_mask = st.w_data[1:0];
				if (st.aw_addr == `IFCLD_REG_IRQ_STAT)
					next_st.irq_stat = st.irq_stat & ~st.w_data[1:0];
			end
		end
		else if (st.bvalid && s_axi_bready)
			next_st.bvalid = 1'b0;
		next_st.irq_stat = next_st.irq_stat | ev;
	end

	// One register stage for the whole block state.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '0;
			st.ctrl_lock_en <= 1'b1;
			st.cnt_state <= CNT_IDLE;
		end
		else
			st <= next_st;
	end

	// Open drain: the pin is only ever pulled low, so the level itself is constant.
	assign data_out_o = 1'b0;

	// Read frames own the pin; otherwise lock mode shows the flag, else it is released.
	always_comb
	begin
		if (st.in_read)
			data_out_oe_n = st.out_sr[20];
		else if (st.ctrl_lock_pin)
			data_out_oe_n = lock_flag;
		else
			data_out_oe_n = 1'b1;
	end

	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rresp = st.rresp;
	assign s_axi_rdata = st.rdata;
	assign irq = |(st.irq_stat & st.irq_mask);
endmodule : ifcld_core

// >>> verilog/ifcld_map.svh
`ifndef IFCLD_MAP_SVH
`define IFCLD_MAP_SVH

// System clock rate in Hz and in kHz.
`define IFCLD_CLK_HZ 125000000
`define IFCLD_CLK_KHZ 125000

// Gate times in milliseconds, one per gate-select code.
`define IFCLD_GATE0_MS 4
`define IFCLD_GATE1_MS 8
`define IFCLD_GATE2_MS 32
`define IFCLD_GATE3_MS 64

// Settle wait in milliseconds for the short and the long gate pairs.
`define IFCLD_WAIT_SHORT_MS 4
`define IFCLD_WAIT_LONG_MS 8

// Comparison reference rates in Hz and their select codes.
`define IFCLD_REF_9K_HZ 9000
`define IFCLD_REF_25K_HZ 25000
`define IFCLD_REF_5K_HZ 5000
`define IFCLD_REF_1K_HZ 1000
`define IFCLD_REF_9K_CODE 4'h9
`define IFCLD_REF_25K_CODE 4'h2
`define IFCLD_REF_5K_CODE 4'hA

// Serial control word: length and bit positions in order of arrival.
`define IFCLD_WORD_LEN 28
`define IFCLD_W_DIV_LSB 0
`define IFCLD_W_AM_SPEED 16
`define IFCLD_W_PRESC_PATH 17
`define IFCLD_W_ARM 18
`define IFCLD_W_REF_LSB 20
`define IFCLD_W_GATE_LO 24
`define IFCLD_W_GATE_HI 25
`define IFCLD_W_SENS 26
`define IFCLD_OUT_LEN 21

// Register byte offsets.
`define IFCLD_REG_CTRL 8'h00
`define IFCLD_REG_STATUS 8'h04
`define IFCLD_REG_WORD 8'h08
`define IFCLD_REG_IRQ_STAT 8'h0C
`define IFCLD_REG_IRQ_MASK 8'h10

// Field positions and reset values.
`define IFCLD_CTRL_LOCK_PIN 0
`define IFCLD_CTRL_LOCK_EN 1
`define IFCLD_CTRL_RESET 2'h2
`define IFCLD_ST_LOCK 20
`define IFCLD_ST_BUSY 21
`define IFCLD_ST_DONE 22
`define IFCLD_IRQ_DONE 0
`define IFCLD_IRQ_LOCK 1

`endif

// >>> verilog/ifcld_pkg.sv
package ifcld_pkg;

	// Phases of one IF count operation.
	typedef enum logic [1:0] {CNT_IDLE, CNT_WAIT, CNT_GATE, CNT_DONE} ifcld_cnt_type;

	// Whole state of the main block.
	typedef struct packed {
		logic ctrl_lock_pin;
		logic ctrl_lock_en;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic in_frame;
		logic dir_known;
		logic in_read;
		logic [4:0] bit_cnt;
		logic [27:0] shift_in;
		logic [20:0] out_sr;
		logic [27:0] word;
		logic prev_ce;
		logic prev_cl;
		ifcld_cnt_type cnt_state;
		logic [23:0] cyc_cnt;
		logic [19:0] if_count;
		logic prev_if;
		logic prev_vco;
		logic [23:0] ref_cnt;
		logic [16:0] div_cnt;
		logic [1:0] fp_cnt;
		logic locked;
	} ifcld_state_type;

endpackage : ifcld_pkg

// >>> verilog/ifcld_sync.sv
`timescale 1ns/100ps

// Two-stage synchroniser for a group of pin levels; stage one feeds stage two only.
module ifcld_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// Both stages held in one packed value.
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ifcld_sync_type;

	ifcld_sync_type st;
	ifcld_sync_type next_st;

	// Stage one catches the pin, stage two only ever reads stage one.
	always_comb
	begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	// Reset clears both stages to a constant.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign q = st.s2;
endmodule : ifcld_sync
